// ---- logic/cob_pkg.sv ----
// Shared constants for the CAN to optical store-and-forward bridge.
// Assumes one 250 MHz clock and an APB register bus with 32-bit data.
package cob_pkg;
	// Frame layout: id, ide, rtr, dlc, data
	localparam int FRAME_W = 99;
	localparam int ID_LSB = 70;
	localparam int ID_W = 29;
	localparam int OPT_DEPTH = 128;
	localparam int OPT_CNT_W = 8;
	localparam int OPT_CAP_FAST = 64;
	localparam int OPT_CAP_SLOW = 128;
	localparam int RATE_FAST_MIN_KBIT = 800;
	localparam int WIRE_DEPTH = 10;
	localparam int WIRE_CNT_W = 4;
	localparam int RATE_W = 3;
	localparam int SEQ_W = 8;
	localparam int EVT_CNT_W = 16;
	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_EVENTS = 8'h08;
	localparam int CTRL_SORT_BIT = 0;
	localparam int CTRL_RATE_LSB = 4;
	localparam logic CTRL_SORT_RST = 1'b0;
	localparam logic [RATE_W-1:0] CTRL_RATE_RST = 3'h0;
	localparam int STAT_OPT_CNT_LSB = 0;
	localparam int STAT_WIRE_CNT_LSB = 8;
	localparam int STAT_LINK_BIT = 16;
	localparam int STAT_ERROR_PASSIVE_INDICATOR_BIT = 17;
	localparam int STAT_BUS_OFF_INDICATOR_BIT = 18;
	localparam int STAT_DIS_BIT = 19;
	localparam int EVT_OVF_LSB = 0;
	localparam int EVT_FRAG_LSB = 16;
	// Fill thresholds in percent
	localparam int FILL_LOW_PCT = 30;
	localparam int FILL_HIGH_PCT = 70;
	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int BLINK_HALF_MS = 250;
	localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;

	// Bit rate in kbit/s for each rate selector code
	function automatic int cob_rate_kbit(input logic [RATE_W-1:0] code);
		case (code)
			3'h0: return 125;
			3'h1: return 250;
			3'h2: return 500;
			3'h3: return 10;
			3'h4: return 20;
			3'h5: return 50;
			3'h6: return 800;
			default: return 1000;
		endcase
	endfunction
endpackage

// ---- logic/cob_blink.sv ----
// Free-running blink phase generator for the indicators.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module cob_blink
	import cob_pkg::*;
	#(parameter int HALF_CYCLES = BLINK_HALF_CYCLES) (
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      phase
);
	localparam int CW = $clog2(HALF_CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          phase;
	} cob_blink_type;

	cob_blink_type st_reg;
	cob_blink_type st_next;

	always_comb begin
		st_next = st_reg;
		if (st_reg.cnt >= CW'(HALF_CYCLES - 1)) begin
			st_next.cnt = '0;
			st_next.phase = !st_reg.phase;
		end else begin
			st_next.cnt = st_reg.cnt + CW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign phase = st_reg.phase;
endmodule

// ---- logic/cob_frame_store.sv ----
// Frame store with FIFO or priority release and flush on overflow.
// Assumes cap never exceeds DEPTH and the reader takes rd_frame when it pops.
`timescale 1ns/10ps
module cob_frame_store
	import cob_pkg::*;
	#(parameter int DEPTH = OPT_DEPTH,
	  parameter int CNT_W = OPT_CNT_W) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               wr_valid,
	input  wire logic [FRAME_W-1:0] wr_frame,
	input  wire logic [CNT_W-1:0]   cap,
	input  wire logic               sort_en,
	input  wire logic               flush,
	input  wire logic               rd_ready,
	output logic                    rd_valid,
	output logic [FRAME_W-1:0]      rd_frame,
	output logic [CNT_W-1:0]        count,
	output logic                    overflow
);
	localparam int IDX_W = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0]              vld;
		logic [DEPTH-1:0][FRAME_W-1:0] mem;
		logic [DEPTH-1:0][SEQ_W-1:0]   seq;
		logic [SEQ_W-1:0]              wseq;
		logic [CNT_W-1:0]              cnt;
		logic                          ovf;
	} cob_store_type;

	cob_store_type    st_reg;
	cob_store_type    st_next;
	logic [IDX_W-1:0] best;
	logic [IDX_W-1:0] slot;
	logic             pop;

	always_comb begin
		logic [SEQ_W-1:0] age_i;
		logic [SEQ_W-1:0] age_b;
		logic [ID_W-1:0]  key_i;
		logic [ID_W-1:0]  key_b;
		logic             found;
		logic             free;
		age_i = '0;
		age_b = '0;
		key_i = '0;
		key_b = '0;
		found = 1'b0;
		free = 1'b0;
		best = '0;
		slot = '0;
		// Oldest frame, or lowest identifier with age as tie break
		for (int i = 0; i < DEPTH; i++) begin
			age_i = st_reg.wseq - st_reg.seq[i];
			age_b = st_reg.wseq - st_reg.seq[best];
			key_i = st_reg.mem[i][ID_LSB +: ID_W];
			key_b = st_reg.mem[best][ID_LSB +: ID_W];
			if (st_reg.vld[i] && (!found || (sort_en ? (key_i < key_b ||
			    (key_i == key_b && age_i > age_b)) : age_i > age_b))) begin
				best = IDX_W'(i);
				found = 1'b1;
			end
			if (!st_reg.vld[i] && !free) begin
				slot = IDX_W'(i);
				free = 1'b1;
			end
		end
		rd_valid = found;
		pop = found && rd_ready;
		if (!free) begin
			slot = best;
		end
		st_next = st_reg;
		st_next.ovf = 1'b0;
		if (pop) begin
			st_next.vld[best] = 1'b0;
		end
		if (flush) begin
			st_next.vld = '0;
			st_next.cnt = '0;
		end else if (wr_valid && (st_reg.cnt - CNT_W'(pop)) >= cap) begin
			st_next.vld = '0;
			st_next.cnt = '0;
			st_next.ovf = 1'b1; // R3
		end else if (wr_valid) begin
			st_next.vld[slot] = 1'b1;
			st_next.mem[slot] = wr_frame;
			st_next.seq[slot] = st_reg.wseq;
			st_next.wseq = st_reg.wseq + SEQ_W'(1);
			st_next.cnt = st_reg.cnt + CNT_W'(1) - CNT_W'(pop);
		end else begin
			st_next.cnt = st_reg.cnt - CNT_W'(pop);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_frame = st_reg.mem[best];
	assign count = st_reg.cnt;
	assign overflow = st_reg.ovf;
endmodule

// ---- logic/cob_can_optical_bridge.sv ----
// Store-and-forward bridge between one CAN segment and an optical link.
// Assumes a frame-level CAN controller and optical transceiver around it.
// Functional notes
// (R1) Optical store: 64 frames fast, else 128
// (R2) Fill indicator off, blinking, steady by level
// (R3) Overflow deletes the whole store
// (R4) Optical fragments are never forwarded
// (R5) Link loss raises switching output only
// (R6) Frames sent during interruption are lost
// (R7) Local frames go to ten-frame buffer
// (R8) Release in arrival or priority order
// (R9) Released frames arbitrate on local segment
// (R10) Same process runs in both directions
// (R11) Each segment arbitrates on its own
// (R12) Segment errors stay on their segment
// (R13) Error-passive indicator follows controller state
// (R14) Bus-off is sticky until power cycle
// (R15) Power indicator blinks when disabled or faulty
// (R16) Transmit indicator shows bus driving
// (R17) Receive indicator shows bus receiving
// (R18) Sort setting selects order, default arrival
// (R19) Bit rate configurable per segment
// (R20) Fill percent uses capacity for rate
`timescale 1ns/10ps
module cob_can_optical_bridge
	import cob_pkg::*;
	#(parameter int BLINK_CYCLES = BLINK_HALF_CYCLES) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic [7:0]         paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               can_rx_valid,
	input  wire logic [FRAME_W-1:0] can_rx_frame,
	output logic                    can_tx_valid,
	output logic [FRAME_W-1:0]      can_tx_frame,
	input  wire logic               can_tx_ready,
	output logic                    can_node_enable,
	output logic [RATE_W-1:0]       can_bitrate_code,
	input  wire logic               can_err_passive,
	input  wire logic               can_bus_off,
	input  wire logic               can_tx_active,
	input  wire logic               can_rx_active,
	output logic                    opt_tx_valid,
	output logic [FRAME_W-1:0]      opt_tx_frame,
	input  wire logic               opt_tx_ready,
	output logic                    opt_tx_enable,
	input  wire logic               opt_rx_valid,
	input  wire logic [FRAME_W-1:0] opt_rx_frame,
	input  wire logic               opt_rx_complete,
	input  wire logic               opt_link_ok,
	input  wire logic               link_disable,
	input  wire logic               hw_fault,
	output logic                    link_switch_out,
	output logic                    power_indicator,
	output logic                    fill_indicator,
	output logic                    error_passive_indicator,
	output logic                    bus_off_indicator,
	output logic                    tx_indicator,
	output logic                    rx_indicator
);
	typedef struct packed {
		logic                 sort_en;
		logic [RATE_W-1:0]    rate;
		logic                 bus_off;
		logic                 ctx_valid;
		logic [FRAME_W-1:0]   ctx_frame;
		logic                 otx_valid;
		logic [FRAME_W-1:0]   otx_frame;
		logic [31:0]          prdata;
		logic [EVT_CNT_W-1:0] ovf_cnt;
		logic [EVT_CNT_W-1:0] frag_cnt;
		logic                 ind_link;
		logic                 ind_pwr;
		logic                 ind_fill;
		logic                 ind_error_passive_indicator;
		logic                 ind_bus_off_indicator;
		logic                 ind_tx;
		logic                 ind_rx;
	} cob_bridge_type;

	cob_bridge_type        st_reg;
	cob_bridge_type        st_next;
	logic                  link_up;
	logic [OPT_CNT_W-1:0]  opt_cap;
	logic                  opt_wr;
	logic                  opt_rd_valid;
	logic                  opt_rd_ready;
	logic [FRAME_W-1:0]    opt_rd_frame;
	logic [OPT_CNT_W-1:0]  opt_count;
	logic                  opt_ovf;
	logic                  wire_wr;
	logic                  wire_rd_valid;
	logic                  wire_rd_ready;
	logic [FRAME_W-1:0]    wire_rd_frame;
	logic [WIRE_CNT_W-1:0] wire_count;
	logic                  blink;
	logic                  fill_low;
	logic                  fill_high;
	logic                  apb_setup;
	logic                  apb_access;
	logic                  addr_ok;

	assign link_up = opt_link_ok && !link_disable;
	// Capacity follows the local bit rate
	assign opt_cap = (cob_rate_kbit(st_reg.rate) >= RATE_FAST_MIN_KBIT) ?
		OPT_CNT_W'(OPT_CAP_FAST) : OPT_CNT_W'(OPT_CAP_SLOW); // R1 R20
	// Fragments and frames during interruption are dropped here
	assign opt_wr = opt_rx_valid && opt_rx_complete && link_up; // R4
	assign opt_rd_ready = !st_reg.ctx_valid && !st_reg.bus_off; // R9
	assign wire_wr = can_rx_valid && link_up && wire_count < WIRE_CNT_W'(WIRE_DEPTH); // R7 R6
	assign wire_rd_ready = !st_reg.otx_valid && link_up; // R7

	cob_frame_store #(
		.DEPTH (OPT_DEPTH),
		.CNT_W (OPT_CNT_W)
	) u_optical_side_rx_buffer (
		.pclk     (pclk),
		.presetn  (presetn),
		.wr_valid (opt_wr),
		.wr_frame (opt_rx_frame),
		.cap      (opt_cap),
		.sort_en  (st_reg.sort_en), // R8 R18
		.flush    (1'b0),
		.rd_ready (opt_rd_ready),
		.rd_valid (opt_rd_valid),
		.rd_frame (opt_rd_frame),
		.count    (opt_count),
		.overflow (opt_ovf)
	);

	cob_frame_store #(
		.DEPTH (WIRE_DEPTH),
		.CNT_W (WIRE_CNT_W)
	) u_wire_side_rx_buffer (
		.pclk     (pclk),
		.presetn  (presetn),
		.wr_valid (wire_wr),
		.wr_frame (can_rx_frame),
		.cap      (WIRE_CNT_W'(WIRE_DEPTH)),
		.sort_en  (1'b0),
		.flush    (!link_up), // R6
		.rd_ready (wire_rd_ready),
		.rd_valid (wire_rd_valid),
		.rd_frame (wire_rd_frame),
		.count    (wire_count),
		.overflow ()
	);

	cob_blink #(
		.HALF_CYCLES (BLINK_CYCLES)
	) u_blink (
		.pclk    (pclk),
		.presetn (presetn),
		.phase   (blink)
	);

	assign fill_low = 16'(opt_count) * 16'd100 < 16'(opt_cap) * 16'(FILL_LOW_PCT); // R20
	assign fill_high = 16'(opt_count) * 16'd100 > 16'(opt_cap) * 16'(FILL_HIGH_PCT); // R20
	assign apb_setup = psel && !penable;
	assign apb_access = psel && penable;
	assign addr_ok = paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_EVENTS;

	always_comb begin
		st_next = st_reg;
		// Registers
		if (apb_access && pwrite && paddr == REG_CTRL) begin
			st_next.sort_en = pwdata[CTRL_SORT_BIT]; // R18
			st_next.rate = pwdata[CTRL_RATE_LSB +: RATE_W]; // R19
		end
		if (apb_setup) begin
			st_next.prdata = '0;
			case (paddr)
				REG_CTRL: begin
					st_next.prdata[CTRL_SORT_BIT] = st_reg.sort_en;
					st_next.prdata[CTRL_RATE_LSB +: RATE_W] = st_reg.rate;
				end
				REG_STATUS: begin
					st_next.prdata[STAT_OPT_CNT_LSB +: OPT_CNT_W] = opt_count;
					st_next.prdata[STAT_WIRE_CNT_LSB +: WIRE_CNT_W] = wire_count;
					st_next.prdata[STAT_LINK_BIT] = link_up;
					st_next.prdata[STAT_ERROR_PASSIVE_INDICATOR_BIT] = can_err_passive;
					st_next.prdata[STAT_BUS_OFF_INDICATOR_BIT] = st_reg.bus_off;
					st_next.prdata[STAT_DIS_BIT] = link_disable;
				end
				REG_EVENTS: begin
					st_next.prdata[EVT_OVF_LSB +: EVT_CNT_W] = st_reg.ovf_cnt;
					st_next.prdata[EVT_FRAG_LSB +: EVT_CNT_W] = st_reg.frag_cnt;
				end
				default: begin
					st_next.prdata = '0;
				end
			endcase
		end
		// Local transmit slot, offered to the controller for arbitration
		if (st_reg.ctx_valid && can_tx_ready) begin
			st_next.ctx_valid = 1'b0; // R9 R11
		end
		if (opt_rd_valid && opt_rd_ready) begin
			st_next.ctx_valid = 1'b1;
			st_next.ctx_frame = opt_rd_frame; // R8
		end
		// Bus-off is sticky; only reset clears it
		if (can_bus_off) begin
			st_next.bus_off = 1'b1; // R14
		end
		if (st_reg.bus_off) begin
			st_next.ctx_valid = 1'b0; // R14
		end
		// Optical transmit slot; errors of this segment never reach it
		if (st_reg.otx_valid && opt_tx_ready) begin
			st_next.otx_valid = 1'b0; // R12
		end
		if (wire_rd_valid && wire_rd_ready) begin
			st_next.otx_valid = 1'b1;
			st_next.otx_frame = wire_rd_frame; // R7 R10
		end
		if (!link_up) begin
			st_next.otx_valid = 1'b0; // R6
		end
		// Event counters
		if (opt_rx_valid && !opt_wr) begin
			st_next.frag_cnt = st_reg.frag_cnt + EVT_CNT_W'(1); // R4
		end
		if (opt_ovf) begin
			st_next.ovf_cnt = st_reg.ovf_cnt + EVT_CNT_W'(1); // R3
		end
		// Indicators
		st_next.ind_link = !link_up; // R5
		st_next.ind_pwr = (link_disable || hw_fault) ? blink : 1'b1; // R15
		st_next.ind_fill = fill_high ? 1'b1 : (fill_low ? 1'b0 : blink); // R2
		st_next.ind_error_passive_indicator = can_err_passive; // R13
		st_next.ind_bus_off_indicator = st_reg.bus_off || can_bus_off; // R14
		st_next.ind_tx = can_tx_active; // R16
		st_next.ind_rx = can_rx_active; // R17
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.sort_en <= CTRL_SORT_RST;
			st_reg.rate <= CTRL_RATE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.prdata;
	assign pready = 1'b1;
	assign pslverr = apb_access && !addr_ok;
	assign can_tx_valid = st_reg.ctx_valid;
	assign can_tx_frame = st_reg.ctx_frame;
	assign can_node_enable = !st_reg.bus_off; // R14
	assign can_bitrate_code = st_reg.rate; // R19
	assign opt_tx_valid = st_reg.otx_valid;
	assign opt_tx_frame = st_reg.otx_frame;
	assign opt_tx_enable = !link_disable; // R15
	assign link_switch_out = st_reg.ind_link; // R5
	assign power_indicator = st_reg.ind_pwr;
	assign fill_indicator = st_reg.ind_fill;
	assign error_passive_indicator = st_reg.ind_error_passive_indicator;
	assign bus_off_indicator = st_reg.ind_bus_off_indicator;
	assign tx_indicator = st_reg.ind_tx;
	assign rx_indicator = st_reg.ind_rx;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_cap_rate;
		opt_cap == ((st_reg.rate == 3'h6 || st_reg.rate == 3'h7) ? 8'd64 : 8'd128);
	endproperty
	a_cap_rate: assert property (p_cap_rate) else $error("store capacity wrong"); // R1

	property p_fill_off;
		16'(opt_count) * 16'd100 < 16'(opt_cap) * 16'd30 |=> !fill_indicator;
	endproperty
	a_fill_off: assert property (p_fill_off) else $error("fill lit when low"); // R2

	property p_fill_on;
		16'(opt_count) * 16'd100 > 16'(opt_cap) * 16'd70 |=> fill_indicator;
	endproperty
	a_fill_on: assert property (p_fill_on) else $error("fill not steady"); // R2

	sequence s_store_full_write;
		opt_wr && opt_count >= opt_cap && !(opt_rd_valid && opt_rd_ready);
	endsequence
	property p_overflow_flush;
		s_store_full_write |=> opt_count == 8'd0 && opt_ovf ##1 !opt_ovf;
	endproperty
	a_overflow_flush: assert property (p_overflow_flush) else $error("no flush"); // R3

	property p_fragment_drop;
		opt_rx_valid && !opt_rx_complete |=> opt_count <= $past(opt_count);
	endproperty
	a_fragment_drop: assert property (p_fragment_drop) else $error("fragment stored"); // R4

	property p_link_switch;
		!link_up |=> link_switch_out;
	endproperty
	a_link_switch: assert property (p_link_switch) else $error("switch output low"); // R5

	sequence s_link_lost;
		!link_up;
	endsequence
	property p_lost_frames;
		s_link_lost |=> !opt_tx_valid && wire_count == 4'd0;
	endproperty
	a_lost_frames: assert property (p_lost_frames) else $error("frame kept"); // R6

	property p_tx_hold;
		can_tx_valid && !can_tx_ready && !st_reg.bus_off |=>
			can_tx_valid && $stable(can_tx_frame);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx frame dropped"); // R9

	property p_error_passive_indicator;
		can_err_passive |=> error_passive_indicator;
	endproperty
	a_error_passive_indicator: assert property (p_error_passive_indicator) else $error("error passive not shown"); // R13

	property p_bus_off_sticky;
		$rose(bus_off_indicator) |=> (bus_off_indicator && !can_tx_valid) [*8];
	endproperty
	a_bus_off_sticky: assert property (p_bus_off_sticky) else $error("bus-off left"); // R14

	property p_power_blink;
		link_disable |=> power_indicator == $past(blink);
	endproperty
	a_power_blink: assert property (p_power_blink) else $error("power not blinking"); // R15

	property p_tx_ind;
		can_tx_active |=> tx_indicator;
	endproperty
	a_tx_ind: assert property (p_tx_ind) else $error("tx indicator off"); // R16
endmodule

// ---- tb/cob_can_node_model.sv ----
// Model of the other nodes on the local CAN segment, at frame level.
// Assumes the bench drives stall and calls send from its own clocked flow.
`timescale 1ns/10ps
module cob_can_node_model
	import cob_pkg::*;
	(
	input  wire logic               pclk,
	input  wire logic               stall,
	input  wire logic               can_tx_valid,
	input  wire logic [FRAME_W-1:0] can_tx_frame,
	output logic                    can_tx_ready,
	output logic                    can_tx_active,
	output logic                    can_rx_active,
	output logic                    can_rx_valid,
	output logic [FRAME_W-1:0]      can_rx_frame
);
	logic [FRAME_W-1:0] got [$];

	initial begin
		can_tx_ready = 1'b0;
		can_tx_active = 1'b0;
		can_rx_active = 1'b0;
		can_rx_valid = 1'b0;
		can_rx_frame = '0;
	end

	// Accepts one frame per grant; a stalled segment never grants
	always @(posedge pclk) begin
		if (can_tx_valid && can_tx_ready) begin
			got.push_back(can_tx_frame);
		end
		can_tx_ready <= !stall && can_tx_valid && !can_tx_ready;
		can_tx_active <= can_tx_valid && !stall;
	end

	// One frame from the segment; the frame lines change once released
	task automatic send(input logic [FRAME_W-1:0] f);
		@(posedge pclk);
		can_rx_active <= 1'b1;
		can_rx_valid <= 1'b1;
		can_rx_frame <= f;
		@(posedge pclk);
		can_rx_active <= 1'b0;
		can_rx_valid <= 1'b0;
		can_rx_frame <= ~f;
	endtask
endmodule

// ---- tb/can_optical_store_forward_bridge_tb_top.sv ----
// Self-checking bench for the CAN to optical bridge, one task per scenario.
// Assumes the CAN node model on the segment side and APB driven from here.
`timescale 1ns/10ps
module can_optical_store_forward_bridge_tb_top;
	import cob_pkg::*;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %0t mismatch at line %0d", $time, `__LINE__); end end
	logic               pclk = 1'b0;
	logic               presetn, psel, penable, pwrite, pready, pslverr, er, stall;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rd;
	logic [FRAME_W-1:0] can_rx_frame, can_tx_frame, opt_tx_frame, opt_rx_frame;
	logic [RATE_W-1:0]  rate;
	logic               can_rx_valid, can_tx_valid, can_tx_ready, can_node_enable;
	logic               can_err_passive, can_bus_off, can_tx_active, can_rx_active;
	logic               opt_tx_valid, opt_tx_ready, opt_tx_enable, opt_rx_valid;
	logic               opt_rx_complete, opt_link_ok, link_disable, hw_fault;
	logic               link_switch_out, power_indicator, fill_indicator;
	logic               error_passive_indicator, bus_off_indicator, tx_indicator, rx_indicator;
	bit                 s0, s1;
	int                 errors = 0;
	int                 total_checks = 0;

	always #2 pclk = ~pclk;

	cob_can_optical_bridge #(.BLINK_CYCLES(4)) dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .can_rx_valid(can_rx_valid), .can_rx_frame(can_rx_frame),
		.can_tx_valid(can_tx_valid), .can_tx_frame(can_tx_frame),
		.can_tx_ready(can_tx_ready), .can_node_enable(can_node_enable),
		.can_bitrate_code(rate), .can_err_passive(can_err_passive),
		.can_bus_off(can_bus_off), .can_tx_active(can_tx_active),
		.can_rx_active(can_rx_active), .opt_tx_valid(opt_tx_valid),
		.opt_tx_frame(opt_tx_frame), .opt_tx_ready(opt_tx_ready),
		.opt_tx_enable(opt_tx_enable), .opt_rx_valid(opt_rx_valid),
		.opt_rx_frame(opt_rx_frame), .opt_rx_complete(opt_rx_complete),
		.opt_link_ok(opt_link_ok), .link_disable(link_disable), .hw_fault(hw_fault),
		.link_switch_out(link_switch_out), .power_indicator(power_indicator),
		.fill_indicator(fill_indicator), .error_passive_indicator(error_passive_indicator),
		.bus_off_indicator(bus_off_indicator), .tx_indicator(tx_indicator),
		.rx_indicator(rx_indicator));

	cob_can_node_model node (
		.pclk(pclk), .stall(stall), .can_tx_valid(can_tx_valid),
		.can_tx_frame(can_tx_frame), .can_tx_ready(can_tx_ready),
		.can_tx_active(can_tx_active), .can_rx_active(can_rx_active),
		.can_rx_valid(can_rx_valid), .can_rx_frame(can_rx_frame));

	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic hang;
		errors++;
		report_and_stop();
	endtask

	function automatic logic [FRAME_W-1:0] mk(input logic [ID_W-1:0] id);
		return {id, 2'b00, 4'h8, 35'h0, id};
	endfunction

	// Samples settled outputs after n edges
	task automatic tk(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (pready !== 1'b1) hang();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdst;
		apb(1'b0, REG_STATUS, 32'h0);
	endtask

	task automatic opt_send(input logic [ID_W-1:0] id, input logic c);
		@(posedge pclk);
		opt_rx_valid <= 1'b1;
		opt_rx_frame <= mk(id);
		opt_rx_complete <= c;
		@(posedge pclk);
		opt_rx_valid <= 1'b0;
		opt_rx_frame <= ~mk(id);
	endtask

	task automatic sendn(input int n);
		repeat (n) opt_send(29'h100, 1'b1);
	endtask

	task automatic watch(ref logic sig);
		s0 = 1'b0;
		s1 = 1'b0;
		@(posedge pclk);
		repeat (16) begin
			@(negedge pclk);
			if (sig === 1'b0) s0 = 1'b1;
			if (sig === 1'b1) s1 = 1'b1;
		end
		@(posedge pclk);
	endtask

	task automatic wait_drain;
		int k;
		stall <= 1'b0;
		for (k = 0; k < 500; k++) begin
			rdst();
			if (rd[15:0] === 16'h0 && can_tx_valid === 1'b0) break;
		end
		if (k == 500) hang();
	endtask

	task automatic t_regs;
		apb(1'b0, REG_CTRL, 32'h0);
		`CHK(rd[CTRL_SORT_BIT], CTRL_SORT_RST)
		`CHK(rd[CTRL_RATE_LSB+:RATE_W], CTRL_RATE_RST)
		apb(1'b0, 8'h0c, 32'h0);
		`CHK({er, rd}, 33'h100000000)
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, REG_CTRL, 32'(c) << CTRL_RATE_LSB);
			tk(2);
			`CHK(rate, 3'(c))
		end
		apb(1'b1, REG_CTRL, 32'h0);
	endtask

	task automatic t_order(input logic sort, input logic [ID_W-1:0] e [4]);
		stall <= 1'b1;
		apb(1'b1, REG_CTRL, {31'h0, sort});
		opt_send(29'd9, 1'b1);
		opt_send(29'd5, 1'b1);
		opt_send(29'd3, 1'b1);
		opt_send(29'd7, 1'b1);
		wait_drain();
		`CHK(node.got.size(), 4)
		for (int i = 0; i < 4 && i < node.got.size(); i++) begin
			`CHK(node.got[i], mk(e[i]))
		end
		node.got.delete();
	endtask

	task automatic t_frag;
		opt_send(29'd11, 1'b0);
		tk(6);
		`CHK(can_tx_valid, 1'b0)
		apb(1'b0, REG_EVENTS, 32'h0);
		`CHK(rd[EVT_FRAG_LSB+:16], 16'h1)
	endtask

	task automatic t_fill;
		stall <= 1'b1;
		apb(1'b1, REG_CTRL, 32'h60);
		sendn(20);
		rdst();
		`CHK(rd[7:0], 8'd19)
		watch(fill_indicator);
		`CHK(s1, 1'b0)
		sendn(1);
		watch(fill_indicator);
		`CHK({s0, s1}, 2'b11)
		sendn(24);
		watch(fill_indicator);
		`CHK({s0, s1}, 2'b11)
		sendn(1);
		watch(fill_indicator);
		`CHK({s0, s1}, 2'b01)
		sendn(19);
		rdst();
		`CHK(rd[7:0], 8'd64)
		sendn(1);
		rdst();
		`CHK(rd[7:0], 8'd0)
		apb(1'b0, REG_EVENTS, 32'h0);
		`CHK(rd[EVT_OVF_LSB+:16], 16'h1)
		apb(1'b1, REG_CTRL, 32'h0);
		sendn(100);
		rdst();
		`CHK(rd[7:0], 8'd100)
		watch(fill_indicator);
		`CHK({s0, s1}, 2'b01)
		wait_drain();
		node.got.delete();
	endtask

	task automatic t_link;
		opt_tx_ready <= 1'b0;
		opt_link_ok <= 1'b0;
		tk(3);
		`CHK(link_switch_out, 1'b1)
		`CHK(can_tx_valid, 1'b0)
		node.send(mk(29'd21));
		tk(4);
		`CHK(opt_tx_valid, 1'b0)
		@(posedge pclk);
		opt_link_ok <= 1'b1;
		tk(10);
		`CHK(opt_tx_valid, 1'b0)
		`CHK(link_switch_out, 1'b0)
		for (int i = 0; i < 12; i++) node.send(mk(29'(30 + i)));
		rdst();
		`CHK(rd[STAT_WIRE_CNT_LSB+:4], 4'ha)
		`CHK(opt_tx_frame, mk(29'd30))
		opt_tx_ready <= 1'b1;
		wait_drain();
	endtask

	task automatic t_ind;
		can_err_passive <= 1'b1;
		tk(3);
		`CHK(error_passive_indicator, 1'b1)
		@(posedge pclk);
		can_err_passive <= 1'b0;
		tk(3);
		`CHK(error_passive_indicator, 1'b0)
		watch(power_indicator);
		`CHK({s0, s1}, 2'b01)
		link_disable <= 1'b1;
		tk(2);
		`CHK(opt_tx_enable, 1'b0)
		watch(power_indicator);
		`CHK({s0, s1}, 2'b11)
		link_disable <= 1'b0;
		hw_fault <= 1'b1;
		watch(power_indicator);
		`CHK({s0, s1}, 2'b11)
		hw_fault <= 1'b0;
		fork
			opt_send(29'd12, 1'b1);
			watch(tx_indicator);
		join
		`CHK({s0, s1}, 2'b11)
		fork
			node.send(mk(29'd13));
			watch(rx_indicator);
		join
		`CHK({s0, s1}, 2'b11)
		wait_drain();
		node.got.delete();
		can_bus_off <= 1'b1;
		@(posedge pclk);
		can_bus_off <= 1'b0;
		opt_send(29'd40, 1'b1);
		tk(10);
		`CHK({bus_off_indicator, can_node_enable, can_tx_valid}, 3'b100)
		rdst();
		`CHK(rd[STAT_BUS_OFF_INDICATOR_BIT], 1'b1)
		node.send(mk(29'd50));
		tk(3);
		`CHK(opt_tx_frame, mk(29'd50))
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		stall = 1'b0;
		can_err_passive = 1'b0;
		can_bus_off = 1'b0;
		opt_tx_ready = 1'b1;
		opt_rx_valid = 1'b0;
		opt_rx_frame = '0;
		opt_rx_complete = 1'b0;
		opt_link_ok = 1'b1;
		link_disable = 1'b0;
		hw_fault = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_order(1'b0, '{29'd9, 29'd5, 29'd3, 29'd7});
		t_order(1'b1, '{29'd9, 29'd3, 29'd5, 29'd7});
		t_frag();
		t_fill();
		t_link();
		t_ind();
		report_and_stop();
	end
endmodule
